// [llbif_core.sv]
`timescale 1ns/10ps

`include "llbif_map.svh"

module llbif_core
  import llbif_pkg::*;
#(
  parameter int FIFO_DEPTH = `LLBIF_FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Outgoing octet stream from the client.
  input wire logic tx_valid,
  output logic tx_ready,
  input wire llbif_octet_s tx_octet,
  // Outgoing frame result.
  output logic tx_done,
  output logic tx_collision,
  // Incoming octet stream and frame end.
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_end,
  output llbif_rx_stat_s rx_stat,
  // Bit-rate enable shared with the physical layer.
  output logic bit_tick,
  // Physical layer, transmit.
  output logic transmitting,
  output logic tx_bit_valid,
  output logic tx_bit_data,
  input wire logic tx_bit_done,
  input wire logic collision_detect,
  // Physical layer, receive.
  input wire logic carrier_sense,
  output logic rx_bit_req,
  input wire logic rx_bit_valid,
  input wire logic rx_bit_data
);

  // ----------------------------------------------------------------------
  // Bit-rate divider
  // ----------------------------------------------------------------------
  localparam int BIT_CYC_RAW = `LLBIF_BIT_TIME_NS * `LLBIF_CLK_MHZ / 1000;
  localparam int BIT_CYC = (BIT_CYC_RAW < 1) ? 1 : BIT_CYC_RAW;
  localparam int DW = (BIT_CYC > 1) ? $clog2(BIT_CYC) : 1;
  localparam logic [DW-1:0] DIV_LAST = DW'(BIT_CYC - 1);

  logic [DW-1:0] div_r;

  // bit-rate enable.
  // The physical layer paces its done strobe on this pulse; its receive valid strobes are timed by counting clocks.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= '0;
      bit_tick <= 1'b0;
    end else begin
      div_r <= (div_r == DIV_LAST) ? '0 : div_r + 1'b1;
      bit_tick <= (div_r == DIV_LAST);
    end
  end

  // Serial CRC step, most significant end first, matching x31 first out.
  function automatic logic [31:0] crc_step(input logic [31:0] c,
                                           input logic b);
    logic fb;
    fb = c[31] ^ b;
    crc_step = {c[30:0], 1'b0} ^ (fb ? `LLBIF_CRC_POLY : 32'h00000000);
  endfunction

  // ----------------------------------------------------------------------
  // Transmit buffer
  // ----------------------------------------------------------------------
  llbif_octet_s fifo_out;
  logic fifo_valid;
  logic fifo_pop;

  // Back-pressure: the client stalls whenever the serializer falls behind.
  llbif_fifo #(
    .WIDTH($bits(llbif_octet_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_octet),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out)
  );

  // ----------------------------------------------------------------------
  // Transmit sequencer
  // ----------------------------------------------------------------------
  llbif_tx_e tx_state_r;
  logic [7:0] tx_sh_r;
  logic tx_last_r;
  logic [2:0] tx_bit_r;
  logic [4:0] fcs_bit_r;
  logic [31:0] tx_crc_r;
  logic [31:0] fcs_r;

  // The octet is taken the cycle it is loaded into the shifter.
  assign fifo_pop = (tx_state_r == LLBIF_TX_LOAD) && fifo_valid;

  // one bit per transfer.
  // The bit stays presented until the physical layer reports it sent;
  // a stretched first transfer simply waits longer.
  // long first transfer.
  assign tx_bit_valid = (tx_state_r == LLBIF_TX_DATA) ||
                        (tx_state_r == LLBIF_TX_FCS);
  assign tx_bit_data = (tx_state_r == LLBIF_TX_FCS) ? fcs_r[31]
                                                    : tx_sh_r[0];

  // State walk. Running dry mid-frame stalls in LOAD, so clients should
  // queue the whole frame faster than one octet per eight bit times.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_r <= LLBIF_TX_IDLE;
    end else begin
      unique case (tx_state_r)
        LLBIF_TX_IDLE: begin
          if (fifo_valid && !carrier_sense) begin
            tx_state_r <= LLBIF_TX_LOAD;
          end
        end
        LLBIF_TX_LOAD: begin
          if (fifo_valid) begin
            tx_state_r <= LLBIF_TX_DATA;
          end
        end
        LLBIF_TX_DATA: begin
          if (tx_bit_done && tx_bit_r == `LLBIF_OCTET_LAST) begin
            tx_state_r <= tx_last_r ? LLBIF_TX_FCS : LLBIF_TX_LOAD;
          end
        end
        LLBIF_TX_FCS: begin
          if (tx_bit_done && fcs_bit_r == `LLBIF_FCS_LAST) begin
            tx_state_r <= LLBIF_TX_END;
          end
        end
        LLBIF_TX_END: begin
          tx_state_r <= LLBIF_TX_IDLE;
        end
      endcase
    end
  end

  // transmitting flag.
  // Raised on leaving IDLE, a cycle before the first bit is shown, and
  // dropped once the final check bit has gone.
  // framing by flag only.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      transmitting <= 1'b0;
    end else if (tx_state_r == LLBIF_TX_IDLE && fifo_valid &&
                 !carrier_sense) begin
      transmitting <= 1'b1;
    end else if (tx_state_r == LLBIF_TX_END) begin
      transmitting <= 1'b0;
    end
  end

  // Data shifter and per-octet bit count.
  // whole octets only.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_sh_r <= 8'h00;
      tx_last_r <= 1'b0;
      tx_bit_r <= 3'h0;
    end else if (fifo_pop) begin
      tx_sh_r <= fifo_out.data;
      tx_last_r <= fifo_out.last;
      tx_bit_r <= 3'h0;
    end else if (tx_state_r == LLBIF_TX_DATA && tx_bit_done) begin
      tx_sh_r <= {1'b0, tx_sh_r[7:1]};
      tx_bit_r <= tx_bit_r + 3'h1;
    end
  end

  // check sequence.
  // Accumulates over every data bit; complemented when the last one goes.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_crc_r <= `LLBIF_CRC_INIT;
      fcs_r <= 32'h00000000;
      fcs_bit_r <= 5'h00;
    end else if (tx_state_r == LLBIF_TX_IDLE) begin
      tx_crc_r <= `LLBIF_CRC_INIT;
      fcs_bit_r <= 5'h00;
    end else if (tx_state_r == LLBIF_TX_DATA && tx_bit_done) begin
      tx_crc_r <= crc_step(tx_crc_r, tx_sh_r[0]);
      if (tx_last_r && tx_bit_r == `LLBIF_OCTET_LAST) begin
        fcs_r <= ~crc_step(tx_crc_r, tx_sh_r[0]);
      end
    end else if (tx_state_r == LLBIF_TX_FCS && tx_bit_done) begin
      fcs_r <= {fcs_r[30:0], 1'b0};
      fcs_bit_r <= fcs_bit_r + 5'h01;
    end
  end

  // concurrent collision watch.
  // Sampled every clock, so a collision wholly inside a prolonged first
  // transfer is still caught. Cleared when the next frame starts.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_collision <= 1'b0;
      tx_done <= 1'b0;
    end else begin
      tx_done <= (tx_state_r == LLBIF_TX_END);
      if (tx_state_r != LLBIF_TX_IDLE && collision_detect) begin
        tx_collision <= 1'b1;
      end else if (tx_state_r == LLBIF_TX_IDLE && fifo_valid &&
                   !carrier_sense) begin
        tx_collision <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Receive collector
  // ----------------------------------------------------------------------
  logic crs_d_r;
  logic rx_take;
  logic [7:0] rx_sh_r;
  logic [2:0] rx_bit_r;
  logic [10:0] rx_oct_r;
  logic [5:0] addr_cnt_r;
  logic group_r;
  logic bcast_r;
  logic [31:0] rx_crc_r;

  assign rx_bit_req = carrier_sense;
  // discard at carrier fall.
  // A strobe without carrier is the undefined tail bit and is dropped.
  assign rx_take = rx_bit_valid && carrier_sense;

  // Octet assembly, first bit lands in bit 0.
  // lsb first.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_sh_r <= 8'h00;
      rx_bit_r <= 3'h0;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
    end else begin
      rx_valid <= 1'b0;
      if (rx_take) begin
        rx_sh_r <= {rx_bit_data, rx_sh_r[7:1]};
        rx_bit_r <= rx_bit_r + 3'h1;
        if (rx_bit_r == `LLBIF_OCTET_LAST) begin
          rx_data <= {rx_bit_data, rx_sh_r[7:1]};
          rx_valid <= 1'b1;
        end
      end else if (!carrier_sense) begin
        rx_bit_r <= 3'h0;
      end
    end
  end

  // Octet count, saturating well above the largest valid frame.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_oct_r <= 11'h000;
    end else if (rx_take && rx_bit_r == `LLBIF_OCTET_LAST &&
                 rx_oct_r != `LLBIF_OCT_SAT) begin
      rx_oct_r <= rx_oct_r + 11'h001;
    end else if (!carrier_sense && !crs_d_r) begin
      rx_oct_r <= 11'h000;
    end
  end

  // no null address.
  // Every value is a legal address; only group and broadcast are marked.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_cnt_r <= 6'h00;
      group_r <= 1'b0;
      bcast_r <= 1'b1;
    end else if (rx_take && addr_cnt_r != `LLBIF_ADDR_BITS) begin
      addr_cnt_r <= addr_cnt_r + 6'h01;
      if (addr_cnt_r == 6'h00) begin
        group_r <= rx_bit_data;
      end
      bcast_r <= bcast_r & rx_bit_data;
    end else if (!carrier_sense && !crs_d_r) begin
      addr_cnt_r <= 6'h00;
      bcast_r <= 1'b1;
    end
  end

  // receive check.
  // Running over the check field too leaves a fixed residue when clean.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_crc_r <= `LLBIF_CRC_INIT;
    end else if (rx_take) begin
      rx_crc_r <= crc_step(rx_crc_r, rx_bit_data);
    end else if (!carrier_sense && !crs_d_r) begin
      rx_crc_r <= `LLBIF_CRC_INIT;
    end
  end

  // edges unaligned.
  // Status is judged on bits actually taken, not on carrier timing.
  // length window.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      crs_d_r <= 1'b0;
      rx_end <= 1'b0;
      rx_stat <= '0;
    end else begin
      crs_d_r <= carrier_sense;
      rx_end <= 1'b0;
      if (crs_d_r && !carrier_sense) begin
        rx_end <= 1'b1;
        rx_stat.crc_ok <= (rx_crc_r == `LLBIF_CRC_RESIDUE);
        rx_stat.len_ok <= (rx_oct_r >= `LLBIF_MIN_FRAME) &&
                          (rx_oct_r <= `LLBIF_MAX_FRAME);
        rx_stat.align_err <= (rx_bit_r != 3'h0);
        rx_stat.group <= group_r;
        rx_stat.bcast <= group_r && bcast_r &&
                         (addr_cnt_r == `LLBIF_ADDR_BITS);
      end
    end
  end

endmodule

// [llbif_core_bench.sv]
`timescale 1ns/10ps

`include "llbif_map.svh"

module llbif_core_bench;
  import llbif_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic tx_valid = 1'b0;
  llbif_octet_s tx_octet = '0;
  logic coll_req = 1'b0;
  logic [7:0] first_wait = 8'h00;
  logic tx_ready, tx_done, tx_collision, rx_valid, rx_end, bit_tick;
  logic [7:0] rx_data;
  llbif_rx_stat_s rx_stat;
  logic transmitting, tx_bit_valid, tx_bit_data, tx_bit_done;
  logic collision_detect, carrier_sense, rx_bit_req;
  logic rx_bit_valid, rx_bit_data;
  int num_errors = 0;
  int compares = 0;
  int overlap = 0;
  logic [7:0] rx_q[$];

  always #5 ref_clk = ~ref_clk;

  llbif_core #(.FIFO_DEPTH(4)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_octet(tx_octet),
    .tx_done(tx_done), .tx_collision(tx_collision), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_end(rx_end), .rx_stat(rx_stat),
    .bit_tick(bit_tick), .transmitting(transmitting),
    .tx_bit_valid(tx_bit_valid), .tx_bit_data(tx_bit_data),
    .tx_bit_done(tx_bit_done), .collision_detect(collision_detect),
    .carrier_sense(carrier_sense), .rx_bit_req(rx_bit_req),
    .rx_bit_valid(rx_bit_valid), .rx_bit_data(rx_bit_data));

  llbif_phy_model phy (.ref_clk(ref_clk), .rst_n(rst_n),
    .bit_tick(bit_tick), .transmitting(transmitting),
    .tx_bit_valid(tx_bit_valid), .tx_bit_data(tx_bit_data),
    .tx_bit_done(tx_bit_done), .collision_detect(collision_detect),
    .rx_bit_req(rx_bit_req), .carrier_sense(carrier_sense),
    .rx_bit_valid(rx_bit_valid), .rx_bit_data(rx_bit_data),
    .coll_req(coll_req), .first_wait(first_wait));

  // Octets are collected mid-cycle, where the pulses have settled.
  always @(negedge ref_clk) begin
    if (rx_valid) rx_q.push_back(rx_data);
    if (transmitting && carrier_sense) overlap++;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Own serial CRC, fed in line order, register shifted towards bit 31.
  function automatic logic [31:0] fcs_of(input bit b[$]);
    logic [31:0] c;
    c = `LLBIF_CRC_INIT;
    foreach (b[i]) begin
      c = {c[30:0], 1'b0} ^ ((c[31] ^ b[i]) ? `LLBIF_CRC_POLY : 32'h0);
    end
    return ~c;
  endfunction

  task automatic mk_bits(input logic [7:0] o[$], output bit b[$]);
    foreach (o[i]) begin
      for (int k = 0; k < 8; k++) b.push_back(o[i][k]);
    end
  endtask

  // Waits on a one-cycle pulse with a bound, so a lost pulse cannot hang.
  task automatic wait_done(input bit rx);
    int n;
    n = 0;
    while ((rx ? rx_end : tx_done) !== 1'b1 && n < 20000) begin
      @(negedge ref_clk);
      n++;
    end
    chk(n < 20000, 1, "handshake wait");
  endtask

  task automatic send_tx(input logic [7:0] o[$], input bit stall);
    foreach (o[i]) begin
      while (tx_ready !== 1'b1) @(negedge ref_clk);
      tx_valid = 1'b1;
      tx_octet = {i == o.size() - 1, o[i]};
      @(negedge ref_clk);
      if (stall && i == 4) chk(tx_ready, 0, "fifo full");
    end
    tx_valid = 1'b0;
  endtask

  task automatic chk_tx(input logic [7:0] o[$], output bit e[$]);
    logic [31:0] f;
    mk_bits(o, e);
    f = fcs_of(e);
    for (int k = 31; k >= 0; k--) e.push_back(f[k]);
    chk(phy.tx_q.size(), e.size(), "tx bit count");
    foreach (e[k]) chk(phy.tx_q[k], e[k], "tx bit");
    phy.tx_q.delete();
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_rx(input bit b[$], input logic [4:0] st,
                         input logic [4:0] mask, input string nm);
    logic [7:0] e;
    rx_q.delete();
    phy.rx_frame(b, 37, 4);
    wait_done(1);
    chk(rx_q.size(), b.size() / 8, "octet count");
    for (int n = 0; n < b.size() / 8; n++) begin
      for (int k = 0; k < 8; k++) e[k] = b[8 * n + k];
      chk(rx_q[n], e, "rx octet");
    end
    chk(rx_stat & mask, st, "frame status");
    $display("test %s done", nm);
  endtask

  // Long first bit with a whole collision inside it, fifo filled meanwhile.
  task automatic test_tx_a(input logic [7:0] o[$], output bit e[$]);
    first_wait = 8'h1e;
    fork
      send_tx(o, 1'b1);
      begin
        @(posedge transmitting);
        repeat (40) @(negedge ref_clk);
        coll_req = 1'b1;
        repeat (60) @(negedge ref_clk);
        coll_req = 1'b0;
      end
    join
    wait_done(0);
    chk_tx(o, e);
    chk(tx_collision, 1, "collision flag");
    chk(tx_ready, 1, "fifo drained");
    $display("test tx_stretch done");
  endtask

  // Transmission is offered while a short frame arrives.
  task automatic test_defer(input logic [7:0] ob[$], input logic [7:0] oc[$]);
    bit b[$];
    bit e[$];
    mk_bits(ob, b);
    b.push_back(1'b1);
    b.push_back(1'b0);
    b.push_back(1'b1);
    first_wait = 8'h00;
    fork
      test_rx(b, 5'b00100, 5'b01111, "rx_short_zero_addr");
      begin
        @(posedge carrier_sense);
        send_tx(oc, 1'b0);
      end
    join
    wait_done(0);
    chk(overlap, 0, "tx held off");
    chk(tx_collision, 0, "collision flag clear");
    chk_tx(oc, e);
    test_rx(e, 5'b10010, 5'b11111, "loop_group_short");
  endtask

  task automatic end_of_test();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Broadcast, zero and group destinations; 64 and 63 octet frames.
  initial begin
    logic [7:0] fa[$];
    logic [7:0] fb[$];
    logic [7:0] fc[$];
    bit ea[$];
    for (int i = 0; i < 60; i++) fa.push_back(i < 6 ? 8'hff : 8'(i));
    for (int i = 0; i < 20; i++) fb.push_back(i < 6 ? 8'h00 : 8'(i));
    for (int i = 0; i < 59; i++) fc.push_back(i < 1 ? 8'h01 : 8'(i * 3));
    repeat (10) @(negedge ref_clk);
    rst_n = 1'b1;
    test_tx_a(fa, ea);
    test_rx(ea, 5'b11011, 5'b11111, "loop_broadcast");
    test_defer(fb, fc);
    // One flipped data bit must spoil the check and nothing else.
    ea[100] = ~ea[100];
    test_rx(ea, 5'b01011, 5'b11111, "rx_bad_check");
    end_of_test();
  end

  // Six frames of at most 64 octets at ten cycles a bit, with margin.
  initial begin
    repeat (60000) @(posedge ref_clk);
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test();
  end
endmodule

// [llbif_core_properties.sv]
`timescale 1ns/10ps

module llbif_core_props
  import llbif_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Transmit side.
  input wire logic transmitting,
  input wire logic tx_bit_valid,
  input wire logic tx_bit_data,
  input wire logic tx_bit_done,
  input wire logic tx_done,
  input wire logic collision_detect,
  input wire logic tx_collision,
  // Receive side and bit timing.
  input wire logic carrier_sense,
  input wire logic rx_bit_req,
  input wire logic rx_bit_valid,
  input wire logic rx_valid,
  input wire logic rx_end,
  input wire logic bit_tick
);
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  // All checks share the one clock domain and its reset.
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  AST_TX_HOLD: assert property (
    tx_bit_valid && !tx_bit_done |=> tx_bit_valid && $stable(tx_bit_data))
    else $error("tx bit changed before it was sent");
  AST_TX_NEXT: assert property (
    tx_bit_valid && tx_bit_done |-> ##[1:2] (tx_bit_valid || !transmitting))
    else $error("next tx bit not offered in time");
  AST_TX_LEAD: assert property (
    $rose(transmitting) |-> !tx_bit_valid)
    else $error("bit offered before frame flag");
  AST_TX_SPAN: assert property (
    tx_bit_valid |-> transmitting)
    else $error("bit offered outside a frame");
  AST_TX_FALL: assert property (
    $fell(transmitting) |-> tx_done && !tx_bit_valid)
    else $error("frame end without done pulse");
  AST_DONE_ONLY: assert property (
    tx_done |-> $fell(transmitting) ##1 !tx_done)
    else $error("done pulse out of place");
  AST_COLL: assert property (
    collision_detect && transmitting |=> tx_collision)
    else $error("collision not recorded");
  AST_DEFER: assert property (
    $rose(transmitting) |-> !$past(carrier_sense))
    else $error("transmission began on a busy channel");
  AST_RX_REQ: assert property (
    carrier_sense |-> rx_bit_req)
    else $error("bit fetch not running under carrier");
  AST_RX_END: assert property (
    $fell(carrier_sense) |=> rx_end ##1 !rx_end)
    else $error("frame not closed after carrier fell");
  AST_RX_OCT: assert property (
    rx_valid |-> $past(rx_bit_valid) && $past(carrier_sense))
    else $error("octet out without a taken bit");
  AST_TICK: assert property (
    bit_tick |=> !bit_tick [*8] ##2 bit_tick)
    else $error("bit tick spacing wrong");
endmodule

bind llbif_core llbif_core_props #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .transmitting(transmitting),
  .tx_bit_valid(tx_bit_valid), .tx_bit_data(tx_bit_data),
  .tx_bit_done(tx_bit_done), .tx_done(tx_done),
  .collision_detect(collision_detect), .tx_collision(tx_collision),
  .carrier_sense(carrier_sense), .rx_bit_req(rx_bit_req),
  .rx_bit_valid(rx_bit_valid), .rx_valid(rx_valid), .rx_end(rx_end),
  .bit_tick(bit_tick));

// [llbif_fifo.sv]
`timescale 1ns/10ps

module llbif_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [CW-1:0] count_r;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready = (count_r != CNT_FULL);
  assign out_valid = (count_r != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_r[rd_ptr_r];

  // Storage is written only on an accepted push.
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // Pointers wrap at the depth, which need not be a power of two.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == PTR_LAST) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == PTR_LAST) ? '0 : rd_ptr_r + 1'b1;
      end
    end
  end

  // Occupancy count.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
    end else if (push && !pop) begin
      count_r <= count_r + 1'b1;
    end else if (pop && !push) begin
      count_r <= count_r - 1'b1;
    end
  end

endmodule

// [llbif_map.svh]
`ifndef LLBIF_MAP_SVH
`define LLBIF_MAP_SVH

// ----------------------------------------------------------------------
// Clock and bit timing
// ----------------------------------------------------------------------
`define LLBIF_CLK_MHZ 100
`define LLBIF_BIT_TIME_NS 100
// Channel round trip in bit times, kept by the physical layer.
`define LLBIF_ROUND_TRIP_BT 450

// ----------------------------------------------------------------------
// Frame format
// ----------------------------------------------------------------------
`define LLBIF_ADDR_BITS 6'h30
`define LLBIF_OCTET_LAST 3'h7
`define LLBIF_FCS_LAST 5'h1f
`define LLBIF_MIN_FRAME 11'h040
`define LLBIF_MAX_FRAME 11'h5ee
`define LLBIF_OCT_SAT 11'h7ff

// ----------------------------------------------------------------------
// Check sequence
// ----------------------------------------------------------------------
`define LLBIF_CRC_POLY 32'h04c11db7
`define LLBIF_CRC_INIT 32'hffffffff
`define LLBIF_CRC_RESIDUE 32'hc704dd7b

// ----------------------------------------------------------------------
// Buffering
// ----------------------------------------------------------------------
`define LLBIF_FIFO_DEPTH 4

`endif

// [llbif_phy_model.sv]
`timescale 1ns/10ps

module llbif_phy_model (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Transmit side of the core.
  input wire logic bit_tick,
  input wire logic transmitting,
  input wire logic tx_bit_valid,
  input wire logic tx_bit_data,
  output logic tx_bit_done,
  output logic collision_detect,
  // Receive side of the core.
  input wire logic rx_bit_req,
  output logic carrier_sense,
  output logic rx_bit_valid,
  output logic rx_bit_data,
  // Scenario controls.
  input wire logic coll_req,
  input wire logic [7:0] first_wait
);
  logic first_r;
  logic [7:0] wait_r;
  bit tx_q[$];

  // Lines start quiet so the core sees no traffic at time zero.
  initial begin
    tx_bit_done = 1'b0;
    carrier_sense = 1'b0;
    rx_bit_valid = 1'b0;
    rx_bit_data = 1'b0;
  end

  // held for the whole collision, only while sending
  assign collision_detect = coll_req && transmitting;

  // one bit per tick, first bit stretched by whole ticks
  // Each branch gives the done strobe exactly one value per edge.
  always @(negedge ref_clk) begin
    if (!rst_n || !transmitting) begin
      tx_bit_done <= 1'b0;
      first_r <= 1'b1;
      wait_r <= first_wait;
    end else if (!tx_bit_valid || !bit_tick) begin
      tx_bit_done <= 1'b0;
    end else if (first_r && wait_r != 8'h00) begin
      tx_bit_done <= 1'b0;
      wait_r <= wait_r - 8'h01;
    end else begin
      tx_bit_done <= 1'b1;
      first_r <= 1'b0;
      tx_q.push_back(tx_bit_data);
    end
  end

  // carrier leads and lags; a bit pending at the fall
  // is never delivered, and an idle data line shows the inverse.
  task automatic rx_frame(input bit b[$], input int lead, input int lag);
    @(negedge ref_clk);
    carrier_sense = 1'b1;
    repeat (lead) @(negedge ref_clk);
    foreach (b[i]) begin
      repeat (9) @(negedge ref_clk);
      rx_bit_data = b[i];
      rx_bit_valid = rx_bit_req;
      @(negedge ref_clk);
      rx_bit_valid = 1'b0;
      rx_bit_data = ~b[i];
    end
    repeat (lag) @(negedge ref_clk);
    carrier_sense = 1'b0;
  endtask
endmodule

// [llbif_pkg.sv]
package llbif_pkg;

  // One octet of an outgoing frame, with a mark on the final octet.
  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } llbif_octet_s;

  // Status reported with the end of each received frame.
  typedef struct packed {
    logic crc_ok;
    logic len_ok;
    logic align_err;
    logic group;
    logic bcast;
  } llbif_rx_stat_s;

  // Transmit sequencer states, one-hot.
  typedef enum logic [4:0] {
    LLBIF_TX_IDLE = 5'h01,
    LLBIF_TX_LOAD = 5'h02,
    LLBIF_TX_DATA = 5'h04,
    LLBIF_TX_FCS  = 5'h08,
    LLBIF_TX_END  = 5'h10
  } llbif_tx_e;

endpackage
